// *** hdl/hpb_pkg.sv ***
package hpb_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int NMX_ADDR_W = 5;
  localparam int MUX_ADDR_W = 16;
  localparam int SYNC_W = 2;

  // ----------------------------------------
  // Address mode encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_NONMUX = 2'h0;
  localparam logic [1:0] MODE_MUX_SINGLE = 2'h1;
  localparam logic [1:0] MODE_MUX_DUAL = 2'h2;

  // Straps after capture
  typedef struct packed {
    logic read_dir_pol;
    logic store_en_pol;
    logic select_pol;
    logic latch_pol;
    logic wide16;
    logic dir_enable_mode;
    logic [1:0] addr_mode;
  } hpb_cfg_t;

  localparam hpb_cfg_t CFG_RESET = '0;

  // Transfer phase states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DONE = 4'b1000
  } hpb_state_t;
endpackage

// *** hdl/hpb_if.sv ***
`timescale 1ns/1ps
// Synchronised, polarity-corrected host strobes passed to the front end core
interface hpb_if;
  logic sel;
  logic rd;
  logic wr;
  logic lo_latch;
  logic hi_latch;
  logic [hpb_pkg::DATA_W-1:0] bus_in;
  logic qsel;
  logic [hpb_pkg::NMX_ADDR_W-1:0] addr_in;
  modport src (output sel, rd, wr, lo_latch, hi_latch, bus_in, qsel, addr_in);
  modport dst (input sel, rd, wr, lo_latch, hi_latch, bus_in, qsel, addr_in);
endinterface

// *** hdl/hpb_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module hpb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// *** hdl/hpb_port.sv ***
`timescale 1ns/1ps
// Functional notes
// - Straps are captured on reset release and held thereafter.
// - Read strobe is active low; read/direction strap inverts it.
// - Direction line: high is read, low is write; strap reverses it.
// - Data-phase strobe with direction marks data phase; active low, store strap inverts.
// - Store strobe marks a write; active low, store/enable strap inverts.
// - Transfers are answered only while device select is active; strap inverts.
// - Non-multiplexed queue window select routes access to data queues.
// - Non-multiplexed mode decodes the five dedicated address lines.
// - In 16-bit non-multiplexed mode address bit 0 is ignored.
// - 8-bit non-multiplexed mode ignores and never drives data bits 15-8.
// - Single-phase mux: upper address byte on 15-8, lower on 7-0.
// - Dual-phase mux: both address bytes arrive on bits 7-0.
// - 8-bit dual-phase mode leaves bits 15-8 unused and undriven.
// - Lower latch takes both bytes single-phase, lower byte only dual-phase.
// - Upper latch takes high byte dual-phase; latches capture on inactive edge.
module hpb_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic read_dir_polarity_cfg,
  input wire logic store_enable_polarity_cfg,
  input wire logic select_polarity_cfg,
  input wire logic latch_polarity_cfg,
  input wire logic wide16_cfg,
  input wire logic dir_enable_mode_cfg,
  input wire logic [1:0] addr_mode_cfg,
  input wire logic sel_pin,
  input wire logic rd_pin,
  input wire logic wr_pin,
  input wire logic queue_window_select,
  input wire logic upper_latch_strobe,
  input wire logic lower_latch_strobe,
  input wire logic [hpb_pkg::NMX_ADDR_W-1:0] addr_pin,
  input wire logic [hpb_pkg::DATA_W-1:0] data_in,
  output logic [hpb_pkg::DATA_W-1:0] data_out,
  output logic [hpb_pkg::DATA_W-1:0] data_oe,
  output logic [hpb_pkg::MUX_ADDR_W-1:0] acc_addr,
  output logic acc_queue,
  output logic acc_rd,
  output logic acc_wr,
  output logic [hpb_pkg::DATA_W-1:0] acc_wdata,
  input wire logic [hpb_pkg::DATA_W-1:0] acc_rdata
);
  hpb_if pin_if ();
  hpb_pkg::hpb_cfg_t cfg_reg;
  logic cfg_taken_reg;
  logic pins_valid_reg;
  logic [6+hpb_pkg::NMX_ADDR_W+hpb_pkg::DATA_W-1:0] raw_s;
  logic sel_s, rd_s, wr_s, lo_s, hi_s;
  hpb_pkg::hpb_state_t state_reg, state_next;
  logic lo_prev_reg, hi_prev_reg;
  logic [hpb_pkg::MUX_ADDR_W-1:0] mux_addr_reg;
  logic [hpb_pkg::DATA_W-1:0] rdata_reg, wdata_reg;
  logic [hpb_pkg::MUX_ADDR_W-1:0] addr_reg;
  logic queue_reg, rd_pulse_reg, wr_pulse_reg, drive_reg;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  // Captured on first edge after release; async reset only loads constants
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reg <= hpb_pkg::CFG_RESET;
      cfg_taken_reg <= 1'b0;
      pins_valid_reg <= 1'b0;
    end
    else
    begin
      // Sync stages still hold reset zeros until one edge after capture
      pins_valid_reg <= cfg_taken_reg;
      if (!cfg_taken_reg)
      begin
        cfg_reg <= '{read_dir_polarity_cfg, store_enable_polarity_cfg, select_polarity_cfg,
                     latch_polarity_cfg, wide16_cfg, dir_enable_mode_cfg,
                     addr_mode_cfg};
        cfg_taken_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  hpb_sync #(.W(6 + hpb_pkg::NMX_ADDR_W + hpb_pkg::DATA_W)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({sel_pin, rd_pin, wr_pin, lower_latch_strobe, upper_latch_strobe,
        queue_window_select, addr_pin, data_in}),
    .q(raw_s)
  );

  // Polarity: strobe pins are active low unless strap set; strap XOR gives active-high
  wire sel_raw = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W + 5];
  wire rd_raw = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W + 4];
  wire wr_raw = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W + 3];
  wire lo_raw = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W + 2];
  wire hi_raw = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W + 1];
  wire dir_is_read = rd_raw ^ cfg_reg.read_dir_pol;
  wire enb_active = ~wr_raw ^ cfg_reg.store_en_pol;
  // Reset zeros in the sync stages look like active strobes, so gate select and both latch strobes
  assign pin_if.sel = pins_valid_reg & (~sel_raw ^ cfg_reg.select_pol);
  assign pin_if.rd = cfg_reg.dir_enable_mode ? (enb_active & dir_is_read)
                                             : (~rd_raw ^ cfg_reg.read_dir_pol);
  assign pin_if.wr = cfg_reg.dir_enable_mode ? (enb_active & ~dir_is_read)
                                             : (~wr_raw ^ cfg_reg.store_en_pol);
  assign pin_if.lo_latch = pins_valid_reg & (~lo_raw ^ cfg_reg.latch_pol);
  assign pin_if.hi_latch = pins_valid_reg & (~hi_raw ^ cfg_reg.latch_pol);
  assign pin_if.qsel = raw_s[hpb_pkg::DATA_W + hpb_pkg::NMX_ADDR_W];
  assign pin_if.addr_in = raw_s[hpb_pkg::DATA_W +: hpb_pkg::NMX_ADDR_W];
  assign pin_if.bus_in = raw_s[hpb_pkg::DATA_W-1:0];
  assign sel_s = pin_if.sel;
  assign rd_s = pin_if.rd;
  assign wr_s = pin_if.wr;
  assign lo_s = pin_if.lo_latch;
  assign hi_s = pin_if.hi_latch;

  // ----------------------------------------
  // Address formation
  // ----------------------------------------
  wire is_nonmux = cfg_reg.addr_mode == hpb_pkg::MODE_NONMUX;
  wire is_dual = cfg_reg.addr_mode == hpb_pkg::MODE_MUX_DUAL;
  wire lo_fall = lo_prev_reg & ~lo_s; // Capture on strobe going inactive
  wire hi_fall = hi_prev_reg & ~hi_s;
  wire [hpb_pkg::LANE_W-1:0] lane_lo = pin_if.bus_in[hpb_pkg::LANE_W-1:0];
  wire [hpb_pkg::LANE_W-1:0] lane_hi = pin_if.bus_in[hpb_pkg::DATA_W-1:hpb_pkg::LANE_W];
  // Bit 0 dropped in 16-bit mode so word addresses stay even
  wire [hpb_pkg::NMX_ADDR_W-1:0] nmx_addr =
    cfg_reg.wide16 ? {pin_if.addr_in[hpb_pkg::NMX_ADDR_W-1:1], 1'b0}
                   : pin_if.addr_in;
  wire [hpb_pkg::MUX_ADDR_W-1:0] cur_addr =
    is_nonmux ? {{(hpb_pkg::MUX_ADDR_W-hpb_pkg::NMX_ADDR_W){1'b0}}, nmx_addr} : mux_addr_reg;
  // Upper lanes are ignored wherever 8-bit width disables them
  wire [hpb_pkg::DATA_W-1:0] wdata_in =
    cfg_reg.wide16 ? pin_if.bus_in : {{hpb_pkg::LANE_W{1'b0}}, lane_lo};

  // Multiplexed address latches
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lo_prev_reg <= 1'b0;
      hi_prev_reg <= 1'b0;
      mux_addr_reg <= '0;
    end
    else
    begin
      lo_prev_reg <= lo_s;
      hi_prev_reg <= hi_s;
      if (!is_nonmux && lo_fall)
        mux_addr_reg[hpb_pkg::LANE_W-1:0] <= lane_lo;
      // Both strobes may close in one cycle; each byte has its own source
      if (!is_nonmux && !is_dual && lo_fall)
        mux_addr_reg[hpb_pkg::MUX_ADDR_W-1:hpb_pkg::LANE_W] <= lane_hi;
      else if (is_dual && hi_fall)
        mux_addr_reg[hpb_pkg::MUX_ADDR_W-1:hpb_pkg::LANE_W] <= lane_lo;
    end
  end

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  // One access pulse per strobe; DONE waits for strobe release
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      hpb_pkg::ST_IDLE:
        if (sel_s && rd_s)
          state_next = hpb_pkg::ST_READ;
        else if (sel_s && wr_s)
          state_next = hpb_pkg::ST_WRITE;
      hpb_pkg::ST_READ:
        if (!(sel_s && rd_s))
          state_next = hpb_pkg::ST_IDLE;
      hpb_pkg::ST_WRITE:
        state_next = hpb_pkg::ST_DONE;
      hpb_pkg::ST_DONE:
        if (!(sel_s && wr_s))
          state_next = hpb_pkg::ST_IDLE;
      default:
        state_next = hpb_pkg::ST_IDLE;
    endcase
  end

  // Write data sampled at end of strobe would cost a cycle; hosts hold data with strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= hpb_pkg::ST_IDLE;
      addr_reg <= '0;
      queue_reg <= 1'b0;
      wdata_reg <= '0;
      rd_pulse_reg <= 1'b0;
      wr_pulse_reg <= 1'b0;
      drive_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      rd_pulse_reg <= (state_reg == hpb_pkg::ST_IDLE) && (state_next == hpb_pkg::ST_READ);
      wr_pulse_reg <= (state_reg == hpb_pkg::ST_IDLE) && (state_next == hpb_pkg::ST_WRITE);
      drive_reg <= state_next == hpb_pkg::ST_READ;
      if (state_reg == hpb_pkg::ST_IDLE)
      begin
        addr_reg <= cur_addr;
        queue_reg <= is_nonmux & pin_if.qsel;
        wdata_reg <= wdata_in;
      end
      if (rd_pulse_reg)
        rdata_reg <= acc_rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign acc_addr = addr_reg;
  assign acc_queue = queue_reg;
  assign acc_rd = rd_pulse_reg;
  assign acc_wr = wr_pulse_reg;
  assign acc_wdata = wdata_reg;
  assign data_out = cfg_reg.wide16 ? rdata_reg
                                   : {{hpb_pkg::LANE_W{1'b0}}, rdata_reg[hpb_pkg::LANE_W-1:0]};
  // Upper lane enables forced off in 8-bit width
  assign data_oe = {{hpb_pkg::LANE_W{drive_reg & cfg_reg.wide16}},
                    {hpb_pkg::LANE_W{drive_reg}}};
endmodule

// *** sim/hpb_core_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Core side register window model
// ----------------------------------------
module hpb_core_model (
  input wire logic clk,
  input wire logic [15:0] acc_addr,
  input wire logic acc_queue,
  input wire logic acc_wr,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata
);
  logic [15:0] mem_reg [32];
  // Queue writes are swallowed so they never alias a window word
  always_ff @(posedge clk)
  begin
    if (acc_wr && !acc_queue)
    begin
      mem_reg[acc_addr[4:0]] <= acc_wdata;
    end
  end
  // Unwritten words read unknown, so a stray read cannot pass
  assign acc_rdata = mem_reg[acc_addr[4:0]];
endmodule

// *** sim/hpb_port_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Output relations of the host port
// ----------------------------------------
module hpb_port_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic select_polarity_cfg,
  input wire logic wide16_cfg,
  input wire logic [1:0] addr_mode_cfg,
  input wire logic sel_pin,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic [15:0] acc_addr,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [15:0] acc_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Requests are single cycle and exclusive
  property p_rd_pulse; acc_rd |=> !acc_rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
  property p_wr_pulse; acc_wr |=> !acc_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  property p_excl; !(acc_rd && acc_wr); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  // Select must have been active three edges before a request
  property p_sel; (acc_rd || acc_wr) |-> $past(sel_pin, 3) == select_polarity_cfg; endproperty
  a_sel: assert property (p_sel) else $error("request without select");
  // Drivers switch on only with a read
  property p_oe_rise; $rose(data_oe[0]) |-> acc_rd; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without read");
  property p_oe_on; acc_rd |-> data_oe[7:0] == 8'hff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_dout; acc_rd |=> data_out == ($past(acc_rdata) & (wide16_cfg ? 16'hffff : 16'h00ff));
  endproperty
  a_dout: assert property (p_dout) else $error("read data wrong");
  // Narrow port never drives the upper lane
  property p_narrow; !wide16_cfg |-> data_oe[15:8] == 8'h00 && data_out[15:8] == 8'h00; endproperty
  a_narrow: assert property (p_narrow) else $error("upper lane used");
  property p_a0; (acc_rd || acc_wr) && wide16_cfg && addr_mode_cfg == 2'h0 |-> !acc_addr[0];
  endproperty
  a_a0: assert property (p_a0) else $error("address bit 0 used");
endmodule
bind hpb_port hpb_port_chk u_chk (.clk(clk), .arst_n(arst_n),
  .select_polarity_cfg(select_polarity_cfg), .wide16_cfg(wide16_cfg),
  .addr_mode_cfg(addr_mode_cfg), .sel_pin(sel_pin), .data_out(data_out), .data_oe(data_oe),
  .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_rdata(acc_rdata));

// *** sim/hpb_port_tb_top.sv ***
`timescale 1ns/1ps
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ----------------------------------------
// Host pin level bench
// ----------------------------------------
module hpb_port_tb_top;
  logic clk, arst_n, rp, wp, sp, lp, w16, dm, sel, rd, wr, qs, uls, lls, aq, ard, awr;
  logic [1:0] am;
  logic [4:0] addr;
  logic [15:0] din, dout, doe, aaddr, wdat, rdat, mk;
  int mismatches, samples_checked, wcount;
  hpb_port DUT (.clk(clk), .arst_n(arst_n), .read_dir_polarity_cfg(rp),
    .store_enable_polarity_cfg(wp), .select_polarity_cfg(sp), .latch_polarity_cfg(lp),
    .wide16_cfg(w16), .dir_enable_mode_cfg(dm), .addr_mode_cfg(am), .sel_pin(sel),
    .rd_pin(rd), .wr_pin(wr), .queue_window_select(qs), .upper_latch_strobe(uls),
    .lower_latch_strobe(lls), .addr_pin(addr), .data_in(din), .data_out(dout),
    .data_oe(doe), .acc_addr(aaddr), .acc_queue(aq), .acc_rd(ard), .acc_wr(awr),
    .acc_wdata(wdat), .acc_rdata(rdat));
  hpb_core_model CORE (.clk(clk), .acc_addr(aaddr), .acc_queue(aq), .acc_wr(awr),
    .acc_wdata(wdat), .acc_rdata(rdat));
  initial begin clk = 1'b0; forever #50 clk = ~clk; end
  // Count requests seen at mid cycle, away from the launching edge
  always @(negedge clk) if (awr === 1'b1 || ard === 1'b1) wcount++;
  task report_and_stop;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task idle;
    sel <= ~sp; rd <= ~rp; wr <= ~wp; uls <= ~lp; lls <= ~lp; qs <= 1'b0;
  endtask
  // Boot sets straps under reset, as the port samples them once
  task boot(input logic [7:0] s);
    arst_n <= 1'b0; {rp, wp, sp, lp, w16, dm, am} <= s; addr <= 5'h00; din <= 16'h0000;
    @(posedge clk); idle; mk = w16 ? 16'hffff : 16'h00ff;
    repeat (12) @(posedge clk); arst_n <= 1'b1; repeat (3) @(posedge clk);
  endtask
  task latch(input logic hi, input logic [15:0] v);
    din <= v; if (hi) uls <= lp; else lls <= lp;
    repeat (4) @(posedge clk); uls <= ~lp; lls <= ~lp; repeat (4) @(posedge clk);
  endtask
  task xfer(input logic is_rd, input logic [15:0] ea, input logic [15:0] ed);
    int n;
    sel <= sp;
    if (dm) begin rd <= is_rd ^ rp; wr <= wp; end
    else if (is_rd) rd <= rp; else wr <= wp;
    n = 0;
    do begin @(negedge clk); n++; end while (ard !== 1'b1 && awr !== 1'b1 && n < 12);
    `CK({ard, awr}, {is_rd, ~is_rd})
    `CK(aq, qs)
    if (!qs) `CK(aaddr, ea)
    if (!is_rd) `CK(wdat & mk, ed)
    else begin @(negedge clk); `CK(dout, ed) `CK(doe, mk) end
    @(posedge clk); idle; repeat (6) @(posedge clk); @(negedge clk);
    `CK(doe, 16'h0000)
    @(posedge clk);
  endtask
  initial begin #(100 * 4000); mismatches++; report_and_stop; end
  initial
  begin
    mismatches = 0; samples_checked = 0; wcount = 0;
    boot(8'b0000_1000);
    addr <= 5'h07; din <= 16'h1234; repeat (3) @(posedge clk);
    xfer(1'b0, 16'h0006, 16'h1234);
    xfer(1'b1, 16'h0006, 16'h1234);
    n_sel: begin wcount = 0; wr <= wp; repeat (8) @(posedge clk); wr <= ~wp; end
    repeat (6) @(posedge clk); `CK(wcount, 0)
    // Live read strap flips after capture; held-high read pin must stay idle
    wcount = 0; rp <= 1'b1; sel <= sp; rd <= 1'b1; repeat (8) @(posedge clk);
    rp <= 1'b0; sel <= ~sp; repeat (6) @(posedge clk); `CK(wcount, 0)
    boot(8'b1110_0100);
    qs <= 1'b1; din <= 16'h5a5a; repeat (3) @(posedge clk);
    xfer(1'b0, 16'h0000, 16'h005a);
    addr <= 5'h13; din <= 16'hbeef; repeat (3) @(posedge clk);
    xfer(1'b0, 16'h0013, 16'h00ef);
    xfer(1'b1, 16'h0013, 16'h00ef);
    boot(8'b0000_1001);
    latch(1'b0, 16'ha55a); din <= 16'h0f0f; repeat (3) @(posedge clk);
    xfer(1'b0, 16'ha55a, 16'h0f0f);
    xfer(1'b1, 16'ha55a, 16'h0f0f);
    boot(8'b0001_0010);
    latch(1'b1, 16'hff3c); latch(1'b0, 16'hffc3); din <= 16'h7781;
    xfer(1'b0, 16'h3cc3, 16'h0081);
    xfer(1'b1, 16'h3cc3, 16'h0081);
    report_and_stop;
  end
endmodule
